// File: sarcc_pkg.sv
// constants shared by the converter control block
package sarcc_pkg;
	// ****************************************************************
	// register byte addresses
	// ****************************************************************
	localparam logic [7:0] ADDR_CTRL_A = 8'h00;
	localparam logic [7:0] ADDR_CTRL_B = 8'h04;
	localparam logic [7:0] ADDR_MUX = 8'h08;
	localparam logic [7:0] ADDR_RES_LOW = 8'h0c;
	localparam logic [7:0] ADDR_RES_HIGH = 8'h10;
	localparam logic [7:0] ADDR_POWER = 8'h14;

	// ****************************************************************
	// field positions
	// ****************************************************************
	localparam int CA_ENABLE = 0;
	localparam int CA_START = 1;
	localparam int CA_AUTO = 2;
	localparam int CA_FLAG = 3;
	localparam int CA_IRQ_EN = 4;
	localparam int CA_PRESC_LSB = 5;
	localparam int CB_TSEL_LSB = 0;
	localparam int MX_CHAN_LSB = 0;
	localparam int MX_LEFT = 5;
	localparam int MX_REF_LSB = 6;
	localparam int PW_REDUCE = 0;

	// ****************************************************************
	// widths, reset values and encodings
	// ****************************************************************
	localparam int RES_W = 10;
	localparam int CHAN_W = 4;
	localparam int REF_W = 2;
	localparam int PRESC_W = 3;
	localparam int TSEL_W = 3;
	localparam int PCNT_W = 7;
	localparam int TCNT_W = 5;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic POWER_RST = 1'b0;
	localparam logic [TSEL_W-1:0] TSEL_SELF = 3'h0;
	localparam logic [CHAN_W-1:0] CHAN_BANDGAP = 4'he;
	localparam logic [CHAN_W-1:0] CHAN_GROUND = 4'hf;
	localparam logic [REF_W-1:0] REF_SUPPLY = 2'h1;
	localparam logic [REF_W-1:0] REF_INTERNAL = 2'h3;

	// ****************************************************************
	// conversion timing in converter clock cycles
	// ****************************************************************
	localparam logic [TCNT_W-1:0] NORMAL_CYCLES = 5'd13;
	localparam logic [TCNT_W-1:0] FIRST_CYCLES = 5'd25;
	localparam logic [TCNT_W-1:0] NORMAL_SAMPLE = 5'd1;
	localparam logic [TCNT_W-1:0] FIRST_SAMPLE = 5'd13;

	typedef enum logic [0:0] {
		ST_IDLE = 1'b0,
		ST_CONV = 1'b1
	} sarcc_state_t;
endpackage

// File: sarcc_top.sv
// conversion control logic of a 10-bit successive approximation converter
// ****************************************************************
// Overview of operation
// R1 - 10-bit result, right or left aligned
// R2 - power reduction set blocks enable and start
// R3 - channel/reference applied only while enabled
// R4 - channel field picks pin, ground or bandgap
// R5 - reference field picks supply or internal 1.1V
// R6 - low byte read blocks result updates
// R7 - high byte read lifts the block
// R8 - completion flag set even if result dropped
// R9 - software reads low byte before high byte
// R10 - start bit begins conversion, hardware clears it
// R11 - channel change waits for conversion end
// R12 - trigger select picks the auto trigger source
// R13 - trigger rising edge resets prescaler, starts
// R14 - only a fresh rising edge starts conversion
// R15 - trigger edge during conversion is ignored
// R16 - trigger flags set regardless of enables
// R17 - software clears trigger flag before next event
// R18 - own completion trigger gives free running
// R19 - software start still works with auto trigger
// R20 - start bit reads one during any conversion
// R21 - completion raises interrupt request if enabled
// R22 - 13 cycles, first after enable 25
// R23 - prescaler runs only while enabled
// R24 - completion writes result, sets flag, clears start
// R25 - sample, compare and done handshakes with array
// ****************************************************************
`timescale 1ns/1ps
module sarcc_top #(
	parameter int TRIG_W = 7
) (
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	input wire logic [TRIG_W-1:0] i_trigger_lines,
	input wire logic i_comparator,
	output logic o_analog_enable,
	output logic o_sample,
	output logic o_bit_strobe,
	output logic [sarcc_pkg::RES_W-1:0] o_trial_code,
	output logic o_conv_done,
	output logic [sarcc_pkg::CHAN_W-1:0] o_channel,
	output logic o_sel_ground,
	output logic o_sel_bandgap,
	output logic [7:0] o_sel_pin,
	output logic o_ref_supply,
	output logic o_ref_internal,
	output logic o_irq
);
	// ****************************************************************
	// functions
	// ****************************************************************
	// aligned result as {high byte, low byte}
	function automatic logic [15:0] align(
		input logic [sarcc_pkg::RES_W-1:0] res,
		input logic left
	);
		logic [15:0] v;
		v = {6'h00, res};
		if (left) begin
			v = {res, 6'h00};
		end
		return v;
	endfunction

	// last prescaler count before a converter clock tick
	function automatic logic [sarcc_pkg::PCNT_W-1:0] presc_last(
		input logic [sarcc_pkg::PRESC_W-1:0] sel
	);
		logic [sarcc_pkg::PCNT_W-1:0] v;
		v = 7'h01;
		if (sel != 3'h0) begin
			v = 7'((8'h01 << sel) - 8'h01);
		end
		return v;
	endfunction

	// ****************************************************************
	// registers
	// ****************************************************************
	logic enable_r;
	logic start_req_r;
	logic auto_r;
	logic flag_r;
	logic irq_en_r;
	logic [sarcc_pkg::PRESC_W-1:0] presc_sel_r;
	logic [sarcc_pkg::TSEL_W-1:0] tsel_r;
	logic [sarcc_pkg::CHAN_W-1:0] chan_r;
	logic left_r;
	logic [sarcc_pkg::REF_W-1:0] ref_r;
	logic power_red_r;
	logic [sarcc_pkg::RES_W-1:0] result_r;
	logic lock_r;
	logic [sarcc_pkg::REF_W-1:0] ref_applied_r;
	logic [sarcc_pkg::CHAN_W-1:0] chan_applied_r;
	logic [sarcc_pkg::PCNT_W-1:0] pcnt_r;
	logic [sarcc_pkg::TCNT_W-1:0] tcnt_r;
	logic first_r;
	logic trig_prev_r;
	logic [sarcc_pkg::RES_W-1:0] sar_r;
	logic [3:0] bit_idx_r;
	logic [31:0] prdata_r;
	logic slverr_r;
	sarcc_pkg::sarcc_state_t state_r;

	logic wr_acc;
	logic rd_acc;
	logic eff_en;
	logic tick;
	logic trig_sel;
	logic trig_edge;
	logic sw_start;
	logic conv_start;
	logic done;
	logic restart;
	logic [sarcc_pkg::TCNT_W-1:0] tcnt_nxt;
	logic [sarcc_pkg::TCNT_W-1:0] sample_at;
	logic [sarcc_pkg::TCNT_W-1:0] total;
	logic [15:0] aligned;
	logic [7:0] ctrl_a_rd;

	// ****************************************************************
	// bus decode
	// ****************************************************************
	assign wr_acc = i_psel && i_penable && i_pwrite;
	assign rd_acc = i_psel && i_penable && !i_pwrite;
	assign o_pready = 1'b1;
	assign o_pslverr = slverr_r && i_psel && i_penable;
	assign o_prdata = prdata_r;
	// power reduction overrides the enable bit
	assign eff_en = enable_r && !power_red_r; // [R2]
	assign aligned = align(result_r, left_r); // [R1]

	// ****************************************************************
	// control register A and power register
	// ****************************************************************
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			enable_r <= 1'b0;
			auto_r <= 1'b0;
			irq_en_r <= 1'b0;
			presc_sel_r <= 3'h0;
			power_red_r <= sarcc_pkg::POWER_RST;
		end else if (wr_acc && i_paddr == sarcc_pkg::ADDR_CTRL_A) begin
			// enable cannot be set while powered down
			enable_r <= i_pwdata[sarcc_pkg::CA_ENABLE] && !power_red_r; // [R2]
			auto_r <= i_pwdata[sarcc_pkg::CA_AUTO];
			irq_en_r <= i_pwdata[sarcc_pkg::CA_IRQ_EN];
			presc_sel_r <= i_pwdata[sarcc_pkg::CA_PRESC_LSB +: sarcc_pkg::PRESC_W];
		end else if (wr_acc && i_paddr == sarcc_pkg::ADDR_POWER) begin
			power_red_r <= i_pwdata[sarcc_pkg::PW_REDUCE];
		end
	end

	// ****************************************************************
	// control register B and channel/reference register
	// ****************************************************************
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			tsel_r <= sarcc_pkg::TSEL_SELF;
			chan_r <= 4'h0;
			left_r <= 1'b0;
			ref_r <= 2'h0;
		end else if (wr_acc && i_paddr == sarcc_pkg::ADDR_CTRL_B) begin
			tsel_r <= i_pwdata[sarcc_pkg::CB_TSEL_LSB +: sarcc_pkg::TSEL_W];
		end else if (wr_acc && i_paddr == sarcc_pkg::ADDR_MUX) begin
			chan_r <= i_pwdata[sarcc_pkg::MX_CHAN_LSB +: sarcc_pkg::CHAN_W];
			left_r <= i_pwdata[sarcc_pkg::MX_LEFT];
			ref_r <= i_pwdata[sarcc_pkg::MX_REF_LSB +: sarcc_pkg::REF_W];
		end
	end

	// ****************************************************************
	// software start request
	// ****************************************************************
	assign sw_start = wr_acc && i_paddr == sarcc_pkg::ADDR_CTRL_A &&
		i_pwdata[sarcc_pkg::CA_START] && eff_en; // [R10] [R19] [R2]

	// request waits for the next converter clock tick
	always_ff @(posedge i_clock) begin
		if (i_rst || !eff_en) begin
			start_req_r <= 1'b0;
		end else if (sw_start && state_r == sarcc_pkg::ST_IDLE) begin
			start_req_r <= 1'b1; // [R23]
		end else if (conv_start) begin
			start_req_r <= 1'b0;
		end
	end

	// ****************************************************************
	// trigger selection and edge detect
	// ****************************************************************
	// source 0 is the own completion, handled by restart below
	always_comb begin
		trig_sel = 1'b0;
		if (tsel_r != sarcc_pkg::TSEL_SELF) begin
			trig_sel = i_trigger_lines[tsel_r - 3'h1]; // [R12] [R16]
		end
	end

	// the previous level is tracked even while busy, so an edge seen
	// during a conversion is consumed and never queued
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			trig_prev_r <= 1'b0;
		end else begin
			trig_prev_r <= trig_sel;
		end
	end

	assign trig_edge = auto_r && eff_en && trig_sel && !trig_prev_r &&
		state_r == sarcc_pkg::ST_IDLE; // [R13] [R14] [R15] [R17]

	// ****************************************************************
	// converter clock prescaler
	// ****************************************************************
	always_ff @(posedge i_clock) begin
		if (i_rst || !eff_en || trig_edge) begin
			pcnt_r <= 7'h00; // [R23] [R13]
		end else if (pcnt_r >= presc_last(presc_sel_r)) begin
			pcnt_r <= 7'h00;
		end else begin
			pcnt_r <= pcnt_r + 7'h01;
		end
	end

	assign tick = eff_en && !trig_edge &&
		pcnt_r >= presc_last(presc_sel_r);

	// ****************************************************************
	// conversion sequencing
	// ****************************************************************
	assign conv_start = trig_edge ||
		(start_req_r && tick && state_r == sarcc_pkg::ST_IDLE);
	assign total = first_r ? sarcc_pkg::FIRST_CYCLES :
		sarcc_pkg::NORMAL_CYCLES; // [R22]
	assign sample_at = first_r ? sarcc_pkg::FIRST_SAMPLE :
		sarcc_pkg::NORMAL_SAMPLE;
	assign tcnt_nxt = tcnt_r + 5'd1;
	assign done = state_r == sarcc_pkg::ST_CONV && tick &&
		tcnt_nxt == total; // [R22]
	// completion retriggers itself whether or not the flag was cleared
	assign restart = done && auto_r &&
		tsel_r == sarcc_pkg::TSEL_SELF; // [R18]

	always_ff @(posedge i_clock) begin
		if (i_rst || !eff_en) begin
			state_r <= sarcc_pkg::ST_IDLE;
		end else begin
			case (state_r)
				sarcc_pkg::ST_IDLE: begin
					if (conv_start) begin
						state_r <= sarcc_pkg::ST_CONV;
					end
				end
				sarcc_pkg::ST_CONV: begin
					if (done && !restart) begin
						state_r <= sarcc_pkg::ST_IDLE; // [R24]
					end
				end
				default: begin
					state_r <= sarcc_pkg::ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_rst || conv_start || done) begin
			tcnt_r <= 5'd0;
		end else if (state_r == sarcc_pkg::ST_CONV && tick) begin
			tcnt_r <= tcnt_nxt;
		end
	end

	// first conversion after enabling needs analog warm-up
	always_ff @(posedge i_clock) begin
		if (i_rst || !eff_en) begin
			first_r <= 1'b1;
		end else if (done) begin
			first_r <= 1'b0; // [R22]
		end
	end

	// ****************************************************************
	// successive approximation handshake
	// ****************************************************************
	assign o_sample = state_r == sarcc_pkg::ST_CONV && tick &&
		tcnt_r == sample_at; // [R25]
	assign o_bit_strobe = state_r == sarcc_pkg::ST_CONV && tick &&
		tcnt_r > sample_at && bit_idx_r < 4'(sarcc_pkg::RES_W); // [R25]
	assign o_trial_code = sar_r;

	// comparator is sampled once per converter clock, msb first
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			sar_r <= 10'h000;
			bit_idx_r <= 4'hf;
		end else if (o_sample) begin
			sar_r <= 10'h200;
			bit_idx_r <= 4'(sarcc_pkg::RES_W - 1);
		end else if (o_bit_strobe) begin
			sar_r[bit_idx_r] <= i_comparator; // [R25]
			if (bit_idx_r != 4'h0) begin
				sar_r[bit_idx_r - 4'h1] <= 1'b1;
			end
			bit_idx_r <= bit_idx_r - 4'h1;
		end
	end

	assign o_conv_done = done; // [R25]

	// ****************************************************************
	// result registers and read lock
	// ****************************************************************
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			result_r <= 10'h000;
		end else if (done && !lock_r) begin
			result_r <= sar_r; // [R24] [R6] [R1]
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			lock_r <= 1'b0;
		end else if (rd_acc && i_paddr == sarcc_pkg::ADDR_RES_LOW) begin
			lock_r <= 1'b1; // [R6] [R9]
		end else if (rd_acc && i_paddr == sarcc_pkg::ADDR_RES_HIGH) begin
			lock_r <= 1'b0; // [R7]
		end
	end

	// ****************************************************************
	// completion flag and interrupt
	// ****************************************************************
	// set wins over a write-one clear in the same cycle
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			flag_r <= 1'b0;
		end else if (done) begin
			flag_r <= 1'b1; // [R8] [R16] [R24]
		end else if (wr_acc && i_paddr == sarcc_pkg::ADDR_CTRL_A &&
			i_pwdata[sarcc_pkg::CA_FLAG]) begin
			flag_r <= 1'b0;
		end
	end

	assign o_irq = flag_r && irq_en_r; // [R21]

	// ****************************************************************
	// applied channel and reference
	// ****************************************************************
	// track the written selection only while enabled and idle or completing, so a
	// running conversion keeps its channel
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			chan_applied_r <= 4'h0;
			ref_applied_r <= 2'h0;
		end else if (eff_en && (state_r == sarcc_pkg::ST_IDLE || done)) begin
			chan_applied_r <= chan_r; // [R3] [R11]
			ref_applied_r <= ref_r; // [R3]
		end
	end

	assign o_channel = chan_applied_r;
	assign o_analog_enable = eff_en;
	assign o_sel_ground = chan_applied_r == sarcc_pkg::CHAN_GROUND; // [R4]
	assign o_sel_bandgap = chan_applied_r == sarcc_pkg::CHAN_BANDGAP; // [R4]
	assign o_ref_supply = ref_applied_r == sarcc_pkg::REF_SUPPLY; // [R5]
	assign o_ref_internal = ref_applied_r == sarcc_pkg::REF_INTERNAL; // [R5]

	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_pin
			assign o_sel_pin[gi] = chan_applied_r == 4'(gi); // [R4]
		end
	endgenerate

	// ****************************************************************
	// read data, latched in the setup phase
	// ****************************************************************
	always_comb begin
		ctrl_a_rd = sarcc_pkg::RST_BYTE;
		ctrl_a_rd[sarcc_pkg::CA_ENABLE] = enable_r;
		// busy shows as start for every kind of start
		ctrl_a_rd[sarcc_pkg::CA_START] = start_req_r ||
			state_r == sarcc_pkg::ST_CONV; // [R10] [R20]
		ctrl_a_rd[sarcc_pkg::CA_AUTO] = auto_r;
		ctrl_a_rd[sarcc_pkg::CA_FLAG] = flag_r;
		ctrl_a_rd[sarcc_pkg::CA_IRQ_EN] = irq_en_r;
		ctrl_a_rd[sarcc_pkg::CA_PRESC_LSB +: sarcc_pkg::PRESC_W] = presc_sel_r;
	end

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			prdata_r <= 32'h0000_0000;
			slverr_r <= 1'b0;
		end else if (i_psel && !i_penable) begin
			prdata_r <= 32'h0000_0000;
			slverr_r <= 1'b0;
			case (i_paddr)
				sarcc_pkg::ADDR_CTRL_A: begin
					prdata_r[7:0] <= ctrl_a_rd;
				end
				sarcc_pkg::ADDR_CTRL_B: begin
					prdata_r[sarcc_pkg::TSEL_W-1:0] <= tsel_r;
				end
				sarcc_pkg::ADDR_MUX: begin
					prdata_r[sarcc_pkg::MX_CHAN_LSB +: sarcc_pkg::CHAN_W] <= chan_r;
					prdata_r[sarcc_pkg::MX_LEFT] <= left_r;
					prdata_r[sarcc_pkg::MX_REF_LSB +: sarcc_pkg::REF_W] <= ref_r;
				end
				sarcc_pkg::ADDR_RES_LOW: begin
					prdata_r[7:0] <= aligned[7:0]; // [R1]
				end
				sarcc_pkg::ADDR_RES_HIGH: begin
					prdata_r[7:0] <= aligned[15:8]; // [R1]
				end
				sarcc_pkg::ADDR_POWER: begin
					prdata_r[sarcc_pkg::PW_REDUCE] <= power_red_r;
				end
				default: begin
					slverr_r <= 1'b1;
				end
			endcase
		end
	end
endmodule

// File: sarcc_array_model.sv
// behavioural model of the sample-and-hold and comparator array
`timescale 1ns/1ps
module sarcc_array_model (
	input wire logic i_clock,
	input wire logic i_sample,
	input wire logic i_bit_strobe,
	input wire logic [sarcc_pkg::RES_W-1:0] i_trial_code,
	input wire logic [sarcc_pkg::CHAN_W-1:0] i_channel,
	output logic o_comparator
);
	logic [9:0] held_r = 10'h000;
	logic flip_r = 1'b0;
	always @(posedge i_clock) begin
		flip_r <= ~flip_r;
		if (i_sample) begin
			held_r <= 10'h2b5 ^ {i_channel, 6'h00};
		end
	end
	// decision only valid in strobe cycles, so it wanders otherwise
	assign o_comparator = i_bit_strobe ? (held_r >= i_trial_code) :
		flip_r;
endmodule

// File: sarcc_properties.sv
// assertion checker for the converter control block
`timescale 1ns/1ps
module sarcc_checker (
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic o_pslverr,
	input wire logic o_analog_enable,
	input wire logic o_sample,
	input wire logic o_bit_strobe,
	input wire logic o_conv_done,
	input wire logic [sarcc_pkg::CHAN_W-1:0] o_channel,
	input wire logic o_sel_ground,
	input wire logic [7:0] o_sel_pin,
	input wire logic o_ref_supply,
	input wire logic o_ref_internal,
	input wire logic o_irq
);
	// ****************************************************************
	// conversion tracking
	// ****************************************************************
	logic busy_r;
	logic [3:0] strobes_r;
	always_ff @(posedge i_clock) begin
		// disabling aborts a conversion without a done pulse
		if (i_rst || o_conv_done || !o_analog_enable) begin
			busy_r <= 1'b0;
		end else if (o_sample) begin
			busy_r <= 1'b1;
		end
	end
	always_ff @(posedge i_clock) begin
		if (i_rst || o_sample) begin
			strobes_r <= 4'h0;
		end else if (o_bit_strobe) begin
			strobes_r <= strobes_r + 4'h1;
		end
	end
	default clocking @(posedge i_clock); endclocking
	default disable iff (i_rst);
	// slowest prescale gives 128 clocks a tick
	sequence s_strobe_soon;
		##[2:130] o_bit_strobe;
	endsequence
	sequence s_idle_twice;
		!o_analog_enable ##1 !o_analog_enable;
	endsequence
	// ****************************************************************
	// properties
	// ****************************************************************
	a_slverr_access: assert property (o_pslverr |-> i_psel && i_penable)
		else $error("slave error outside access phase");
	a_sample_enabled: assert property (o_sample |-> o_analog_enable)
		else $error("sample while converter disabled");
	a_done_pulse: assert property (o_conv_done |=> !o_conv_done)
		else $error("done longer than one cycle");
	a_ten_strobes: assert property (o_conv_done |-> strobes_r == 4'ha)
		else $error("bit strobe count wrong at done");
	a_strobe_follows: assert property (o_sample |-> s_strobe_soon)
		else $error("no bit strobe after sample");
	a_channel_locked: assert property (
		busy_r && !o_conv_done |=> $stable(o_channel))
		else $error("channel changed mid conversion");
	a_idle_channel: assert property (s_idle_twice |-> $stable(o_channel))
		else $error("channel applied while disabled");
	a_pin_decode: assert property (o_channel < 4'h8 |->
		o_sel_pin == (8'h01 << o_channel) && !o_sel_ground)
		else $error("pin select decode wrong");
	a_ground_decode: assert property (
		o_channel == sarcc_pkg::CHAN_GROUND |->
		o_sel_ground && o_sel_pin == 8'h00)
		else $error("ground select decode wrong");
	a_ref_exclusive: assert property (!(o_ref_supply && o_ref_internal))
		else $error("two references at once");
	a_irq_cause: assert property ($rose(o_irq) |->
		o_conv_done || $past(o_conv_done) ||
		$past(i_psel && i_penable && i_pwrite &&
		i_paddr == sarcc_pkg::ADDR_CTRL_A))
		else $error("interrupt without completion");
endmodule

bind sarcc_top sarcc_checker chk_i (
	.i_clock(i_clock),
	.i_rst(i_rst),
	.i_psel(i_psel),
	.i_penable(i_penable),
	.i_pwrite(i_pwrite),
	.i_paddr(i_paddr),
	.o_pslverr(o_pslverr),
	.o_analog_enable(o_analog_enable),
	.o_sample(o_sample),
	.o_bit_strobe(o_bit_strobe),
	.o_conv_done(o_conv_done),
	.o_channel(o_channel),
	.o_sel_ground(o_sel_ground),
	.o_sel_pin(o_sel_pin),
	.o_ref_supply(o_ref_supply),
	.o_ref_internal(o_ref_internal),
	.o_irq(o_irq)
);

// File: testbench.sv
// self-checking testbench for the converter control block
`timescale 1ns/1ps
module testbench;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [6:0] trig = 7'h00;
	logic [31:0] prdata, rd_d;
	logic pready, pslverr, comp, aen, smp, stb, done, gnd, bg, rsup, rint;
	logic irq, rd_e;
	logic [9:0] trial;
	logic [3:0] chan;
	logic [7:0] pin;
	int bad_count = 0;
	int compares = 0;
	int done_cnt = 0;
	int n, d0;
	always #10 clk = ~clk;
	always @(posedge clk) if (done === 1'b1) done_cnt <= done_cnt + 1;
	sarcc_top sarcc_top_i (.i_clock(clk), .i_rst(rst), .i_psel(psel),
		.i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
		.i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
		.o_pslverr(pslverr), .i_trigger_lines(trig), .i_comparator(comp),
		.o_analog_enable(aen), .o_sample(smp), .o_bit_strobe(stb),
		.o_trial_code(trial), .o_conv_done(done), .o_channel(chan),
		.o_sel_ground(gnd), .o_sel_bandgap(bg), .o_sel_pin(pin),
		.o_ref_supply(rsup), .o_ref_internal(rint), .o_irq(irq));
	sarcc_array_model sarcc_array_model_i (.i_clock(clk), .i_sample(smp),
		.i_bit_strobe(stb), .i_trial_code(trial), .i_channel(chan),
		.o_comparator(comp));
	// ****************************************************************
	// tasks
	// ****************************************************************
	function automatic logic [9:0] lvl(input logic [3:0] c);
		return 10'h2b5 ^ {c, 6'h00};
	endfunction
	task end_sim();
		if (bad_count == 0 && compares > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("Error %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task chk_n(input int got, input int lo, input int hi);
		compares++;
		if (got < lo || got > hi) begin
			bad_count++;
			$display("Error %0t got %h exp %h-%h", $time, got, lo, hi);
		end
	endtask
	task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		rd_d = prdata;
		rd_e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k >= 50) begin
			bad_count++;
			end_sim();
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		xfer(a, 1'b1, d);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] exp);
		xfer(a, 1'b0, 32'h0);
		chk(rd_d, exp);
	endtask
	task wait_done(output int c);
		c = 0;
		do begin
			@(posedge clk);
			c++;
		end while (done !== 1'b1 && c < 300);
		if (c >= 300) begin
			bad_count++;
			end_sim();
		end
	endtask
	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		for (int a = 0; a < 24; a += 4) rd(8'(a), 32'h0);
		xfer(8'h18, 1'b0, 32'h0);
		chk({31'h0, rd_e}, 32'h1);
		xfer(8'h18, 1'b1, 32'hff);
		chk({31'h0, rd_e}, 32'h1);
		wr(sarcc_pkg::ADDR_POWER, 32'h1);
		wr(sarcc_pkg::ADDR_CTRL_A, 32'h23);
		xfer(sarcc_pkg::ADDR_CTRL_A, 1'b0, 32'h0);
		chk(rd_d & 32'h3, 32'h0);
		chk({31'h0, aen}, 32'h0);
		wr(sarcc_pkg::ADDR_POWER, 32'h0);
		wr(sarcc_pkg::ADDR_MUX, 32'h43);
		repeat (2) @(posedge clk);
		chk({28'h0, chan}, 32'h0);
		wr(sarcc_pkg::ADDR_CTRL_A, 32'h21);
		repeat (2) @(posedge clk);
		chk({27'h0, rsup, chan}, 32'h13);
		wr(sarcc_pkg::ADDR_CTRL_A, 32'h23);
		wait_done(n);
		chk_n(n, 46, 56);
		rd(sarcc_pkg::ADDR_CTRL_A, 32'h29);
		rd(sarcc_pkg::ADDR_RES_LOW, {24'h0, 8'(lvl(3))});
		rd(sarcc_pkg::ADDR_RES_HIGH, 32'(lvl(3) >> 8));
		wr(sarcc_pkg::ADDR_CTRL_A, 32'h23);
		rd(sarcc_pkg::ADDR_CTRL_A, 32'h2b);
		wait_done(n);
		chk_n(n, 18, 32);
		wr(sarcc_pkg::ADDR_MUX, 32'h63);
		rd(sarcc_pkg::ADDR_RES_LOW, {24'h0, 8'(lvl(3) << 6)});
		rd(sarcc_pkg::ADDR_RES_HIGH, 32'(lvl(3) >> 2));
		// right alignment again: low byte holds the lower eight bits
		wr(sarcc_pkg::ADDR_MUX, 32'h45);
		rd(sarcc_pkg::ADDR_RES_LOW, {24'h0, 8'(lvl(3))});
		wr(sarcc_pkg::ADDR_MUX, 32'h05);
		wr(sarcc_pkg::ADDR_CTRL_A, 32'h2b);
		repeat (6) @(posedge clk);
		wr(sarcc_pkg::ADDR_MUX, 32'h46);
		chk({28'h0, chan}, 32'h5);
		wait_done(n);
		rd(sarcc_pkg::ADDR_CTRL_A, 32'h29);
		rd(sarcc_pkg::ADDR_RES_HIGH, 32'(lvl(3) >> 8));
		wr(sarcc_pkg::ADDR_CTRL_A, 32'h3b);
		wait_done(n);
		@(posedge clk);
		chk({31'h0, irq}, 32'h1);
		rd(sarcc_pkg::ADDR_RES_LOW, {24'h0, 8'(lvl(6))});
		rd(sarcc_pkg::ADDR_RES_HIGH, 32'(lvl(6) >> 8));
		wr(sarcc_pkg::ADDR_CTRL_A, 32'h29);
		// the clear lands at the access edge, so look one cycle later
		@(posedge clk);
		chk({31'h0, irq}, 32'h0);
		wr(sarcc_pkg::ADDR_MUX, 32'hc6);
		repeat (2) @(posedge clk);
		chk({30'h0, rint, rsup}, 32'h2);
		wr(sarcc_pkg::ADDR_MUX, 32'h4f);
		repeat (2) @(posedge clk);
		chk({30'h0, gnd, bg}, 32'h2);
		wr(sarcc_pkg::ADDR_MUX, 32'h4e);
		repeat (2) @(posedge clk);
		chk({30'h0, gnd, bg}, 32'h1);
		wr(sarcc_pkg::ADDR_CTRL_A, 32'h2d);
		for (int s = 1; s < 8; s++) begin
			wr(sarcc_pkg::ADDR_CTRL_B, 32'(s));
			d0 = done_cnt;
			trig[s-1] <= 1'b1;
			repeat (10) @(posedge clk);
			trig[s-1] <= 1'b0;
			repeat (2) @(posedge clk);
			trig[s-1] <= 1'b1;
			repeat (70) @(posedge clk);
			chk_n(done_cnt - d0, 1, 1);
			trig[s-1] <= 1'b0;
			repeat (4) @(posedge clk);
		end
		wr(sarcc_pkg::ADDR_CTRL_B, 32'h1);
		wr(sarcc_pkg::ADDR_CTRL_A, 32'h27);
		wait_done(n);
		chk_n(n, 18, 32);
		wr(sarcc_pkg::ADDR_CTRL_B, 32'h0);
		d0 = done_cnt;
		repeat (60) @(posedge clk);
		chk_n(done_cnt - d0, 0, 0);
		wr(sarcc_pkg::ADDR_CTRL_A, 32'h27);
		d0 = done_cnt;
		repeat (120) @(posedge clk);
		chk_n(done_cnt - d0, 3, 5);
		end_sim();
	end
endmodule
